// ==== dv/qcs_top_tb_top.sv ====
// self-checking bench for the questionable condition register block
// assumes qcs_pkg and qcs_top compiled first; inputs move on falling edges
`timescale 1ns/1ps
module qcs_top_tb_top
    import qcs_pkg::*;
;
    logic CLK;
    logic RST_B;
    logic [22:0] src;
    logic SELFTEST_FAIL;
    logic [1:0] CAL_VARIANT;
    logic BERT_FITTED;
    logic COLD_SRC;
    logic WR_REQ;
    logic CLR_STATUS;
    logic QRY_REQ;
    logic [15:0] COND;
    logic WR_IGNORED;
    logic CLR_DONE;
    logic QRY_BUSY;
    logic QRY_DONE;
    logic [15:0] QRY_VALUE;
    logic [19:0] QRY_BCD;
    logic [2:0] QRY_NDIG;
    int n_fail;
    int num_checks;

    qcs_top qcs_top_i (
        .CLK(CLK),
        .RST_B(RST_B),
        .PWR_FLAGS(src[1:0]),
        .LVL_DET_COLD(src[2]),
        .OVEN_COLD(src[3]),
        .LOCK_FLAGS(src[9:4]),
        .MOD_FLAGS(src[14:10]),
        .CAL_FLAGS(src[16:15]),
        .BERT_FLAGS(src[22:17]),
        .SELFTEST_FAIL(SELFTEST_FAIL),
        .CAL_VARIANT(CAL_VARIANT),
        .BERT_FITTED(BERT_FITTED),
        .COLD_SRC(COLD_SRC),
        .WR_REQ(WR_REQ),
        .CLR_STATUS(CLR_STATUS),
        .QRY_REQ(QRY_REQ),
        .COND(COND),
        .WR_IGNORED(WR_IGNORED),
        .CLR_DONE(CLR_DONE),
        .QRY_BUSY(QRY_BUSY),
        .QRY_DONE(QRY_DONE),
        .QRY_VALUE(QRY_VALUE),
        .QRY_BCD(QRY_BCD),
        .QRY_NDIG(QRY_NDIG)
    );

    always #12.5 CLK = ~CLK;

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // expected register image, worked out from the pins and straps
    function automatic logic [15:0] exp_cond(input logic [22:0] s,
        input logic st);
        logic [15:0] e;
        e = 16'h0000;
        e[3] = |s[1:0];
        e[4] = COLD_SRC ? s[2] : s[3];
        e[5] = |s[9:4];
        e[7] = |s[14:10];
        case (CAL_VARIANT)
            2'h0: e[8] = |s[16:15];
            2'h1: e[8] = s[16];
            2'h2: e[8] = s[15];
            default: e[8] = 1'b0;
        endcase
        e[9] = st;
        e[12] = BERT_FITTED & (|s[22:17]);
        return e;
    endfunction : exp_cond

    // three edges through the synchroniser, sampled on the fourth fall
    task automatic settle();
        repeat (4) @(negedge CLK);
    endtask : settle

    task automatic do_reset(input int cycles);
        RST_B = 1'b0;
        repeat (cycles) @(negedge CLK);
        check(COND, 16'h0000);
        check(QRY_NDIG, 3'h1);
        check(QRY_BUSY, 1'b0);
        RST_B = 1'b1;
        settle();
    endtask : do_reset

    task automatic query(input logic [15:0] exp);
        logic [19:0] bcd;
        logic [2:0] nd;
        int v;
        int k;
        v = exp;
        nd = 3'h1;
        for (k = 0; k < 5; k++) begin
            bcd[4*k +: 4] = 4'(v % 10);
            if (v >= 10 && k < 4) nd = 3'(k + 2);
            v = v / 10;
        end
        QRY_REQ = 1'b1;
        @(negedge CLK);
        QRY_REQ = 1'b0;
        check(QRY_BUSY, 1'b1);
        check(QRY_VALUE, exp);
        // second request while busy, with the pins moved: must be dropped
        src = ~src;
        QRY_REQ = 1'b1;
        @(negedge CLK);
        QRY_REQ = 1'b0;
        for (k = 0; k < 30 && QRY_DONE !== 1'b1; k++) @(negedge CLK);
        if (k == 30) begin
            n_fail++;
            tally_and_finish();
        end
        check(k, 16);
        check(QRY_VALUE, exp);
        check(QRY_BCD, bcd);
        check(QRY_NDIG, nd);
        @(negedge CLK);
        check({QRY_DONE, QRY_BUSY}, 2'h0);
        src = ~src;
        settle();
    endtask : query

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int cfg;
        int i;
        CLK = 1'b0;
        RST_B = 1'b0;
        src = 23'h0;
        SELFTEST_FAIL = 1'b0;
        CAL_VARIANT = 2'h0;
        BERT_FITTED = 1'b1;
        COLD_SRC = 1'b0;
        WR_REQ = 1'b0;
        CLR_STATUS = 1'b0;
        QRY_REQ = 1'b0;
        n_fail = 0;
        num_checks = 0;
        @(negedge CLK);
        do_reset(11);

        // every source alone, then all at once, across every CAL_VARIANT and BERT_FITTED pair
        for (cfg = 0; cfg < 8; cfg++) begin
            CAL_VARIANT = 2'(cfg);
            BERT_FITTED = cfg[2];
            COLD_SRC = cfg[0] ^ cfg[2];
            do_reset(3);
            for (i = 0; i <= 23; i++) begin
                src = (i == 23) ? '1 : 23'(1) << i;
                settle();
                check(COND, exp_cond(src, 1'b0));
                check(COND, exp_cond(src, 1'b0));
                check(COND, exp_cond(src, 1'b0));
                check(COND, exp_cond(src, 1'b0));
            end
            src = 23'h0;
            settle();
            check(COND, 16'h0000);
        end
        $display("test sources done");

        CAL_VARIANT = 2'h0;
        BERT_FITTED = 1'b1;
        COLD_SRC = 1'b0;
        do_reset(3);
        src = 23'h1;
        settle();
        WR_REQ = 1'b1;
        @(negedge CLK);
        WR_REQ = 1'b0;
        check(WR_IGNORED, 1'b1);
        check(COND, 16'h0008);
        src = 23'h0;
        settle();
        check(COND, 16'h0000);
        $display("test write done");

        SELFTEST_FAIL = 1'b1;
        @(negedge CLK);
        SELFTEST_FAIL = 1'b0;
        settle();
        check(COND, 16'h0200);
        CLR_STATUS = 1'b1;
        @(negedge CLK);
        CLR_STATUS = 1'b0;
        check(CLR_DONE, 1'b1);
        settle();
        check(COND, 16'h0200);
        $display("test selftest done");

        src = 23'h1;
        settle();
        query(16'd520);
        src = '1;
        settle();
        query(exp_cond(src, 1'b1));
        do_reset(3);
        check(COND, exp_cond(src, 1'b0));
        $display("test query done");
        tally_and_finish();
    end
endmodule : qcs_top_tb_top

// ==== src/qcs_bcd_conv.sv ====
// sequential binary to packed-decimal converter, one bit per clock
// assumes start is only raised while busy is low
`timescale 1ns/1ps
module qcs_bcd_conv
    import qcs_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rst_b, // synchronous reset, active low
    qcs_conv_if.conv cv // request and result
);

    logic [35:0] shift_q, shift_d;
    logic [4:0] cnt_q, cnt_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic [19:0] bcd_q, bcd_d;

    // add three to every digit of five or more before the shift
    function automatic logic [35:0] dabble(input logic [35:0] v);
        logic [35:0] r;
        r = v;
        for (int i = 0; i < QCS_DIGITS; i++) begin
            if (r[16 + 4 * i +: 4] >= 4'h5) begin
                r[16 + 4 * i +: 4] = r[16 + 4 * i +: 4] + 4'h3;
            end
        end
        return r;
    endfunction : dabble

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [35:0] nxt;
        nxt = dabble(shift_q);
        nxt = {nxt[34:0], 1'b0};
        shift_d = shift_q;
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        bcd_d = bcd_q;
        if (!busy_q && cv.start) begin
            shift_d = {20'h00000, cv.bin};
            cnt_d = QCS_CONV_STEPS;
            busy_d = 1'b1;
        end else if (busy_q) begin
            shift_d = nxt;
            cnt_d = cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                bcd_d = nxt[35:16];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            shift_q <= 36'h000000000;
            cnt_q <= 5'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            bcd_q <= 20'h00000;
        end else begin
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
            bcd_q <= bcd_d;
        end
    end

    assign cv.busy = busy_q;
    assign cv.done = done_q;
    assign cv.bcd = bcd_q;

endmodule : qcs_bcd_conv

// ==== src/qcs_conv_if.sv ====
// carrier between the query controller and the decimal converter
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface qcs_conv_if;
    logic start;
    logic [15:0] bin;
    logic busy;
    logic done;
    logic [19:0] bcd;
    modport ctrl(output start, output bin, input busy, input done,
        input bcd);
    modport conv(input start, input bin, output busy, output done,
        output bcd);
endinterface : qcs_conv_if

// ==== src/qcs_pkg.sv ====
// constants and types for the questionable condition status block
// assumes one system clock; power-up reset is the only reset
package qcs_pkg;

    // condition register layout
    localparam int QCS_W = 16;
    localparam logic [15:0] QCS_COND_RST = 16'h0000;
    localparam logic [15:0] QCS_RSVD_MASK = 16'hec47;
    localparam int QCS_B_POWER = 3;
    localparam int QCS_B_COLD = 4;
    localparam int QCS_B_FREQ = 5;
    localparam int QCS_B_MOD = 7;
    localparam int QCS_B_CAL = 8;
    localparam int QCS_B_SELF = 9;
    localparam int QCS_B_BERT = 12;

    // source group widths
    localparam int QCS_PWR_N = 2;
    localparam int QCS_LOCK_N = 6;
    localparam int QCS_MOD_N = 5;
    localparam int QCS_CAL_N = 2;
    localparam int QCS_BERT_N = 6;
    localparam int QCS_CAL_FMPM = 0;
    localparam int QCS_CAL_IQ = 1;

    // field positions in the synchronised pin vector
    localparam int QCS_R_PWR = 0;
    localparam int QCS_R_COLD_DET = 2;
    localparam int QCS_R_OVEN = 3;
    localparam int QCS_R_LOCK = 4;
    localparam int QCS_R_MOD = 10;
    localparam int QCS_R_CAL = 15;
    localparam int QCS_R_BERT = 17;
    localparam int QCS_R_SELF = 23;
    localparam int QCS_R_CALV = 24;
    localparam int QCS_R_BERTF = 26;
    localparam int QCS_R_COLDSRC = 27;
    localparam int QCS_RAW_W = 28;

    // post-reset timing: sync depth, then live
    localparam logic [1:0] QCS_STRAP_CNT = 2'h2;
    localparam logic [1:0] QCS_LIVE_CNT = 2'h3;

    // decimal conversion
    localparam int QCS_DIGITS = 5;
    localparam int QCS_BCD_W = 20;
    localparam logic [4:0] QCS_CONV_STEPS = 5'h10;
    localparam logic [2:0] QCS_NDIG_MIN = 3'h1;

    typedef enum logic [1:0] {
        QCS_CAL_BOTH = 2'h0,
        QCS_CAL_IQ_ONLY = 2'h1,
        QCS_CAL_DC_ONLY = 2'h2,
        QCS_CAL_NONE = 2'h3
    } qcs_cal_var_t;

    typedef enum logic [2:0] {
        QCS_Q_IDLE = 3'b001,
        QCS_Q_CONV = 3'b010,
        QCS_Q_DONE = 3'b100
    } qcs_qstate_t;

endpackage : qcs_pkg

// ==== src/qcs_top.sv ====
// questionable condition register: live status mirror with decimal query
// assumes status and strap pins are asynchronous to CLK
`timescale 1ns/1ps

// Behaviour
// - condition register is read-only, live, and writes change nothing
// - bits 0,1,2,6,10,11,13,14,15 always read zero
// - bit 3 is high when leveling fails or reverse protection trips
// - bit 4 is high while the selected heated element is cold
// - bit 5 is high when any synthesizer or reference loop loses lock
// - bit 7 is high on modulation range faults or uncalibrated modulation
// - bit 8 is high on fm/pm zero calibration or I/Q calibration error
// - some variants route only one calibration error onto bit 8
// - variants with neither calibration error routed hold bit 8 at zero
// - bit 9 flags power-up self-test failure until power is cycled
// - bit 12 is high on any bit-error-tester fault
// - variants without bit-error tester hold bit 12 at zero
// - a query returns the decimal sum of the set bit weights
module qcs_top
    import qcs_pkg::*;
(
    input wire logic CLK, // system clock, 40 MHz
    input wire logic RST_B, // synchronous power-up reset, active low
    input wire logic [1:0] PWR_FLAGS, // unleveled, reverse protection
    input wire logic LVL_DET_COLD, // auto_level_loop detector cold
    input wire logic OVEN_COLD, // reference oscillator oven cold
    input wire logic [5:0] LOCK_FLAGS, // loss-of-lock sources
    input wire logic [4:0] MOD_FLAGS, // range and uncal sources
    input wire logic [1:0] CAL_FLAGS, // dc_coupled_fm_pm, I/Q errors
    input wire logic [5:0] BERT_FLAGS, // bit_error_test_status_group
    input wire logic SELFTEST_FAIL, // self-test failure report
    input wire logic [1:0] CAL_VARIANT, // strap: calibration routing
    input wire logic BERT_FITTED, // strap: bit-error tester present
    input wire logic COLD_SRC, // strap: 1 detector, 0 oven
    input wire logic WR_REQ, // attempted write to the register
    input wire logic CLR_STATUS, // clear-status command pulse
    input wire logic QRY_REQ, // condition query request
    output logic [15:0] COND, // live condition register
    output logic WR_IGNORED, // write seen and discarded
    output logic CLR_DONE, // clear-status seen
    output logic QRY_BUSY, // query in progress
    output logic QRY_DONE, // query answer valid, one cycle
    output logic [15:0] QRY_VALUE, // snapshot queried
    output logic [19:0] QRY_BCD, // decimal digits of snapshot
    output logic [2:0] QRY_NDIG // significant decimal digits
);

    qcs_conv_if cv();

    logic [QCS_RAW_W-1:0] raw, sync1_q, sync2_q;
    logic [1:0] cnt_q, cnt_d;
    qcs_cal_var_t calv_q, calv_d;
    logic bertf_q, bertf_d;
    logic coldsrc_q, coldsrc_d;
    logic self_q, self_d;
    logic [15:0] cond_q, cond_d;
    logic wr_ign_q, clr_q;
    qcs_qstate_t state_q, state_d;
    logic [15:0] snap_q, snap_d;
    logic [19:0] bcd_q, bcd_d;
    logic [2:0] ndig_q, ndig_d;
    logic live;

    // calibration summary per variant
    function automatic logic cal_sel(input qcs_cal_var_t v,
        input logic [QCS_CAL_N-1:0] f);
        unique case (v)
            QCS_CAL_BOTH: cal_sel = |f;
            QCS_CAL_IQ_ONLY: cal_sel = f[QCS_CAL_IQ];
            QCS_CAL_DC_ONLY: cal_sel = f[QCS_CAL_FMPM];
            QCS_CAL_NONE: cal_sel = 1'b0;
        endcase
    endfunction : cal_sel

    // significant digits, zero shows as one digit
    function automatic logic [2:0] digit_count(input logic [19:0] b);
        logic [2:0] n;
        n = QCS_NDIG_MIN;
        for (int i = 1; i < QCS_DIGITS; i++) begin
            if (b[4 * i +: 4] != 4'h0) begin
                n = 3'(i + 1);
            end
        end
        return n;
    endfunction : digit_count

    // packed decimal back to binary, for checking only
    function automatic logic [16:0] bcd_value(input logic [19:0] b);
        logic [16:0] s;
        s = 17'h00000;
        for (int i = QCS_DIGITS - 1; i >= 0; i--) begin
            s = 17'(s * 17'h0000a + 17'(b[4 * i +: 4]));
        end
        return s;
    endfunction : bcd_value

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers; sync1 feeds only sync2
    assign raw = {COLD_SRC, BERT_FITTED, CAL_VARIANT, SELFTEST_FAIL,
        BERT_FLAGS, CAL_FLAGS, MOD_FLAGS, LOCK_FLAGS, OVEN_COLD,
        LVL_DET_COLD, PWR_FLAGS};

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // straps are caught once the synchronisers hold real pin levels;
    // until then the optional sources stay masked off
    always_comb begin
        cnt_d = cnt_q;
        calv_d = calv_q;
        bertf_d = bertf_q;
        coldsrc_d = coldsrc_q;
        if (cnt_q != QCS_LIVE_CNT) begin
            cnt_d = cnt_q + 2'h1;
        end
        if (cnt_q == QCS_STRAP_CNT) begin
            calv_d = qcs_cal_var_t'(sync2_q[QCS_R_CALV +: 2]);
            bertf_d = sync2_q[QCS_R_BERTF];
            coldsrc_d = sync2_q[QCS_R_COLDSRC];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            cnt_q <= 2'h0;
            calv_q <= QCS_CAL_NONE;
            bertf_q <= 1'b0;
            coldsrc_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            calv_q <= calv_d;
            bertf_q <= bertf_d;
            coldsrc_q <= coldsrc_d;
        end
    end

    assign live = (cnt_q == QCS_LIVE_CNT);

    ////////////////////////////////////////////////////////////////////
    // condition register: rebuilt every cycle, nothing latched except
    // the self-test flag, which only reset (power cycle) clears
    always_comb begin
        self_d = self_q | sync2_q[QCS_R_SELF];
        cond_d = QCS_COND_RST;
        cond_d[QCS_B_POWER] =
            |sync2_q[QCS_R_PWR +: QCS_PWR_N];
        cond_d[QCS_B_COLD] = coldsrc_d ? sync2_q[QCS_R_COLD_DET]
            : sync2_q[QCS_R_OVEN];
        cond_d[QCS_B_FREQ] =
            |sync2_q[QCS_R_LOCK +: QCS_LOCK_N];
        cond_d[QCS_B_MOD] =
            |sync2_q[QCS_R_MOD +: QCS_MOD_N];
        cond_d[QCS_B_CAL] = cal_sel(calv_d,
            sync2_q[QCS_R_CAL +: QCS_CAL_N]);
        cond_d[QCS_B_SELF] = self_d;
        cond_d[QCS_B_BERT] = bertf_d
            & (|sync2_q[QCS_R_BERT +: QCS_BERT_N]);
    end

    // writes and clear-status are acknowledged but reach no state
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            self_q <= 1'b0;
            cond_q <= QCS_COND_RST;
            wr_ign_q <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            self_q <= self_d;
            cond_q <= cond_d;
            wr_ign_q <= WR_REQ;
            clr_q <= CLR_STATUS;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // query: snapshot, convert to decimal, present for one cycle
    always_comb begin
        state_d = state_q;
        snap_d = snap_q;
        bcd_d = bcd_q;
        ndig_d = ndig_q;
        unique case (state_q)
            QCS_Q_IDLE: begin
                if (QRY_REQ) begin
                    state_d = QCS_Q_CONV;
                    snap_d = cond_q;
                end
            end
            QCS_Q_CONV: begin
                if (cv.done) begin
                    state_d = QCS_Q_DONE;
                    bcd_d = cv.bcd;
                    ndig_d = digit_count(cv.bcd);
                end
            end
            QCS_Q_DONE: state_d = QCS_Q_IDLE;
            default: state_d = QCS_Q_IDLE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            state_q <= QCS_Q_IDLE;
            snap_q <= QCS_COND_RST;
            bcd_q <= 20'h00000;
            ndig_q <= QCS_NDIG_MIN;
        end else begin
            state_q <= state_d;
            snap_q <= snap_d;
            bcd_q <= bcd_d;
            ndig_q <= ndig_d;
        end
    end

    assign cv.start = (state_q == QCS_Q_IDLE) && QRY_REQ;
    assign cv.bin = cond_q;

    qcs_bcd_conv u_conv (
        .clk(CLK),
        .rst_b(RST_B),
        .cv(cv)
    );

    assign COND = cond_q;
    assign WR_IGNORED = wr_ign_q;
    assign CLR_DONE = clr_q;
    assign QRY_BUSY = (state_q != QCS_Q_IDLE);
    assign QRY_DONE = (state_q == QCS_Q_DONE);
    assign QRY_VALUE = snap_q;
    assign QRY_BCD = bcd_q;
    assign QRY_NDIG = ndig_q;

    ////////////////////////////////////////////////////////////////////
    // checks: pins reach COND three edges after they are sampled
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);

    a_rsvd_bits_zero: assert property (
        (COND & QCS_RSVD_MASK) == 16'h0000)
        else $error("reserved condition bit set");

    a_power_summary: assert property (
        live |-> COND[QCS_B_POWER] == $past(|PWR_FLAGS, 3))
        else $error("power summary wrong");

    a_cold_select: assert property (
        live |-> COND[QCS_B_COLD] == (coldsrc_q ? $past(LVL_DET_COLD, 3)
            : $past(OVEN_COLD, 3)))
        else $error("cold flag wrong");

    a_lock_summary: assert property (
        live |-> COND[QCS_B_FREQ] == $past(|LOCK_FLAGS, 3))
        else $error("lock summary wrong");

    a_mod_summary: assert property (
        live |-> COND[QCS_B_MOD] == $past(|MOD_FLAGS, 3))
        else $error("modulation summary wrong");

    a_cal_both: assert property (
        live && calv_q == QCS_CAL_BOTH
            |-> COND[QCS_B_CAL] == $past(|CAL_FLAGS, 3))
        else $error("calibration summary wrong");

    a_cal_iq_only: assert property (
        live && calv_q == QCS_CAL_IQ_ONLY
            |-> COND[QCS_B_CAL] == $past(CAL_FLAGS[QCS_CAL_IQ], 3))
        else $error("I/Q-only calibration bit wrong");

    a_cal_dc_only: assert property (
        live && calv_q == QCS_CAL_DC_ONLY
            |-> COND[QCS_B_CAL] == $past(CAL_FLAGS[QCS_CAL_FMPM], 3))
        else $error("fm/pm-only calibration bit wrong");

    a_cal_none_zero: assert property (
        calv_q == QCS_CAL_NONE |-> !COND[QCS_B_CAL])
        else $error("calibration bit set on variant without it");

    a_selftest_sticky: assert property (
        COND[QCS_B_SELF] |=> COND[QCS_B_SELF][*8])
        else $error("self-test flag dropped");

    a_selftest_set: assert property (
        live && $past(SELFTEST_FAIL, 3) |-> COND[QCS_B_SELF])
        else $error("self-test failure not shown");

    a_bert_summary: assert property (
        live && bertf_q |-> COND[QCS_B_BERT] == $past(|BERT_FLAGS, 3))
        else $error("bit-error summary wrong");

    a_bert_absent: assert property (
        !bertf_q |-> !COND[QCS_B_BERT])
        else $error("bit-error bit set without tester");

    a_query_timing: assert property (
        QRY_REQ && !QRY_BUSY |=> QRY_BUSY ##17 QRY_DONE)
        else $error("query answer late or early");

    a_query_value: assert property (
        QRY_DONE |-> bcd_value(QRY_BCD) == {1'b0, QRY_VALUE})
        else $error("decimal answer does not match snapshot");

endmodule : qcs_top
